/* design/rss_pkg.sv */
package rss_pkg;

  // ---------------------------------------------------------------------
  // counter and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 50;   // ref_clk rate
  localparam int unsigned CNT_W          = 13;   // stabilisation counter
  localparam int unsigned STAB_CYC       = 4096; // long stabilisation
  localparam int unsigned SHORT_CYC      = 32;   // short stop recovery
  localparam int unsigned DRIVE_CYC      = 32;   // pin drive, internal rst
  localparam int unsigned HOLD_CYC       = 32;   // extra internal reset
  localparam int unsigned PIN_MIN_CYC    = 67;   // pin flag, other resets
  localparam int unsigned PIN_MIN_POR    = 4163; // pin flag after por/lvi
  localparam int unsigned SVC_CLR_LSB    = 4;    // lowest bit cleared on svc
  localparam int unsigned WDOG_W         = 8;    // watchdog tick counter

  // ---------------------------------------------------------------------
  // vectors and addresses
  // ---------------------------------------------------------------------
  localparam logic [15:0] VEC_USER       = 16'hfffe;
  localparam logic [15:0] VEC_MON        = 16'hfefe;
  localparam logic [15:0] SVC_ADDR       = 16'hffff;

  // ---------------------------------------------------------------------
  // apb register map (byte offsets)
  // ---------------------------------------------------------------------
  localparam logic [11:0] OFS_CAUSE      = 12'h000; // reset cause, ro
  localparam logic [11:0] OFS_CTRL       = 12'h004; // options, rw
  localparam logic [11:0] OFS_STAT       = 12'h008; // live status, ro

  // cause bit positions
  localparam int unsigned B_POR          = 7;
  localparam int unsigned B_PIN          = 6;
  localparam int unsigned B_WDG          = 5;
  localparam int unsigned B_OPC          = 4;
  localparam int unsigned B_ADR          = 3;
  localparam int unsigned B_LVI          = 1;
  localparam logic [7:0]  CAUSE_RST      = 8'h80;

  // ctrl bit positions
  localparam int unsigned B_SHORT_STOP_RECOVERY        = 0;
  localparam int unsigned B_HALT_EN      = 1;
  localparam int unsigned B_MON          = 2;
  localparam logic [2:0]  CTRL_RST       = 3'h0;

  typedef enum logic [2:0] {
    ST_STAB  = 3'b000,  // long count, pin driven
    ST_DRIVE = 3'b001,  // pin driven
    ST_HOLD  = 3'b010,  // internal reset only
    ST_RUN   = 3'b011,
    ST_STOP  = 3'b100,
    ST_WAKE  = 3'b101,
    ST_EXT   = 3'b110   // pin held low from outside
  } rss_state_t;

  // cpu-side event inputs
  typedef struct packed {
    logic bad_opcode;   // illegal instruction decoded
    logic stop_exec;    // stop instruction executed
    logic wait_exec;    // wait instruction executed
    logic opcode_fetch; // current fetch is an opcode
    logic unmapped;     // current access hits no device
    logic wr;           // cpu write strobe
    logic [15:0] addr;  // cpu address
    logic wake;         // interrupt or break wake request
  } rss_cpu_t;

endpackage

/* design/rss_seq.sv */
// Behaviour
// - stop exit: counter timing, clocks off
// - wait mode stops cpu clock only
// - every reset asserts internal reset, vector
// - internal reset returns all to defaults
// - internal reset clears counter, pin doesn't
// - each source sets its cause flag
// - pin flag needs 67 or 4163 cycles
// - drive pin 32, hold reset 32 more
// - por/lvi drive pin 4096 first
// - watchdog reset accepted asynchronously
// - power-on: clock out, 4096 then 64
// - por sets por flag, clears others
// - watchdog overflow resets, sets flag
// - write ffff clears watchdog, counter 12:4
// - counter overflow ticks the watchdog
// - monitor high voltage disables watchdog
// - illegal opcode sets flag, resets
// - stop illegal when halt disabled
// - unmapped opcode fetch resets, data doesn't
// - low voltage: flag, 4096, release later
// - 13-bit free-running counter, overflow ticks
// - stop clears counter, 32 or 4096 wake
// - cause register read-only, resets 0x80
`timescale 1ns/1ns
`default_nettype none
module rss_seq
  import rss_pkg::*;
#(
  parameter int unsigned STAB_N = STAB_CYC,    // long count, shortenable
  parameter int unsigned PINP_N = PIN_MIN_POR, // pin qualify after por
  parameter int unsigned WDOG_N = 8'hff        // watchdog overflow count
) (
  input  wire logic        ref_clk,        // osc_ref_clock, 50 MHz
  input  wire logic        rst,            // power-on pulse, async high
  input  wire logic        lvi_in,         // low-voltage detect
  input  wire logic        wdog_rst_in,    // external watchdog reset req
  input  wire logic        rst_pin_in,     // ext_reset_pin_n level
  input  wire logic        hv_rst,         // high voltage on reset pin
  input  wire logic        hv_irq,         // high voltage on ext_irq_pin
  input  wire logic        brk_state,      // break state active
  input  wire rss_cpu_t    cpu,            // cpu event bundle
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [11:0] paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             rst_pin_out,    // pin drive value, always 0
  output logic             rst_pin_oe_n,   // low while pin driven low
  output logic             internal_reset, // to all modules
  output logic      [15:0] vector_addr,    // reset vector to cpu
  output logic             gen_clock_out,  // clock generator enable
  output logic             cpu_clk_en,     // cpu clock gate
  output logic             per_clk_en,     // peripheral clock gate
  output logic             wdog_tick       // one pulse per overflow
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  localparam logic [12:0] STAB_T  = 13'(STAB_N - 1);
  localparam logic [12:0] SHORT_T = 13'(SHORT_CYC - 1);
  localparam logic [12:0] DRV_T   = 13'(DRIVE_CYC - 1);
  localparam logic [12:0] HLD_T   = 13'(HOLD_CYC - 1);
  localparam logic [12:0] PIN_T   = 13'(PIN_MIN_CYC - 1);
  localparam logic [12:0] PINP_T  = 13'(PINP_N - 1);

  rss_state_t        st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [12:0]       ph_q;        // phase counter
  logic [12:0]       pin_cnt_q;   // pin low duration
  logic              por_src_q;   // last internal reset was por/lvi
  logic [7:0]        cause_q;
  logic [2:0]        ctrl_q;
  logic [7:0]        wd_q;
  logic              wd_s1_q;
  logic              wd_s2_q;
  logic              wd_p_q;
  logic              lvi_q;
  logic              ovf_q;
  logic              wait_q;      // cpu parked in wait mode

  logic ctrl_short_stop_recovery;
  logic ctrl_halt;
  logic ctrl_mon;
  assign ctrl_short_stop_recovery = ctrl_q[B_SHORT_STOP_RECOVERY];
  assign ctrl_halt  = ctrl_q[B_HALT_EN];
  assign ctrl_mon   = ctrl_q[B_MON];

  // ---------------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------------
  logic wd_en;
  logic wd_ovf;
  logic wd_edge;
  logic opc_ev;
  logic adr_ev;
  logic lvi_ev;
  logic svc_wr;
  logic int_ev;
  logic running;
  assign running = (st_q == ST_RUN) || (st_q == ST_STOP)
                || (st_q == ST_WAKE);
  // high voltage gates watchdog purely combinationally, noise-safe
  assign wd_en   = !((ctrl_mon && (hv_rst || hv_irq))
                  || (brk_state && hv_rst));
  assign wd_edge = wd_s2_q && !wd_p_q;
  assign wd_ovf  = wd_en && ((wdog_tick && (wd_q == 8'(WDOG_N - 1)))
                  || wd_edge);
  assign opc_ev  = cpu.bad_opcode
                || (cpu.stop_exec && !ctrl_halt);
  assign adr_ev  = cpu.unmapped && cpu.opcode_fetch;
  assign lvi_ev  = lvi_in && !lvi_q;
  assign svc_wr  = cpu.wr && (cpu.addr == SVC_ADDR);
  assign int_ev  = running
                && (wd_ovf || opc_ev || adr_ev || lvi_ev);

  // ---------------------------------------------------------------------
  // synchronise watchdog request; it arrives from any clock
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_s1_q <= 1'b0;
      wd_s2_q <= 1'b0;
      wd_p_q  <= 1'b0;
      lvi_q   <= 1'b0;
    end else begin
      wd_s1_q <= wdog_rst_in;
      wd_s2_q <= wd_s1_q;
      wd_p_q  <= wd_s2_q;
      lvi_q   <= lvi_in;
    end
  end

  // ---------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q      <= ST_STAB;
      ph_q      <= 13'h0000;
      por_src_q <= 1'b1;
    end else begin
      ph_q <= ph_q + 13'h0001;
      case (st_q)
        ST_STAB: if (ph_q == STAB_T) begin
          st_q <= ST_DRIVE;
          ph_q <= 13'h0000;
        end
        ST_DRIVE: if (ph_q == DRV_T) begin
          st_q <= ST_HOLD;
          ph_q <= 13'h0000;
        end
        ST_HOLD: if (ph_q == HLD_T) begin
          st_q <= ST_RUN;
          ph_q <= 13'h0000;
        end
        ST_RUN: begin
          if (cpu.stop_exec && ctrl_halt) begin
            st_q <= ST_STOP;
          end
        end
        ST_STOP: if (cpu.wake) begin
          st_q <= ST_WAKE;
          ph_q <= 13'h0000;
        end
        ST_WAKE: if (ph_q == (ctrl_short_stop_recovery ? SHORT_T : STAB_T)) begin
          st_q <= ST_RUN;
        end
        ST_EXT: if (rst_pin_in) begin
          st_q <= ST_HOLD;               // pin release, then reset tail
          ph_q <= 13'h0000;
        end
        default: st_q <= ST_STAB;
      endcase
      // internal sources win over everything once running
      if (int_ev) begin
        st_q      <= lvi_ev ? ST_STAB : ST_DRIVE;
        ph_q      <= 13'h0000;
        por_src_q <= lvi_ev;
      end else if (!rst_pin_in && running) begin
        st_q      <= ST_EXT;
        por_src_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // stabilisation counter, advances every cycle not cleared by reset, stop or service (falling osc edge
  // modelled as ref_clk rising; one domain keeps timing simple)
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q     <= '0;
      ovf_q     <= 1'b0;
      wdog_tick <= 1'b0;
    end else begin
      ovf_q     <= &cnt_q;
      wdog_tick <= (&cnt_q) && !ovf_q;
      if (int_ev || (st_q == ST_STOP)
          || (cpu.stop_exec && ctrl_halt)) begin
        cnt_q <= '0;
      end else if (svc_wr) begin
        cnt_q <= {9'h000, cnt_q[SVC_CLR_LSB-1:0] + 4'h1};
      end else begin
        cnt_q <= cnt_q + 13'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // watchdog counter, prescaled by counter overflow
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_q <= 8'h00;
    end else if (svc_wr || internal_reset || !wd_en) begin
      wd_q <= 8'h00;
    end else if (wdog_tick) begin
      wd_q <= wd_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------------
  // pin low duration, qualifies the pin flag
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_cnt_q <= 13'h0000;
    end else if (rst_pin_in) begin
      pin_cnt_q <= 13'h0000;
    end else if (pin_cnt_q != 13'h1fff) begin
      pin_cnt_q <= pin_cnt_q + 13'h0001;
    end
  end

  logic pin_qual;
  assign pin_qual = !rst_pin_in && !rst_pin_oe_n == 1'b0
                 && (pin_cnt_q == (por_src_q ? PINP_T : PIN_T));

  // ---------------------------------------------------------------------
  // cause register; set beats nothing since it is read-only
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_q <= CAUSE_RST;
    end else if (int_ev) begin
      cause_q <= 8'h00;
      cause_q[B_WDG] <= wd_ovf;
      cause_q[B_OPC] <= opc_ev;
      cause_q[B_ADR] <= adr_ev;
      cause_q[B_LVI] <= lvi_ev;
    end else if (pin_qual) begin
      cause_q <= 8'h00;
      cause_q[B_PIN] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // apb slave, zero wait states
  // ---------------------------------------------------------------------
  logic acc;
  logic hit;
  assign acc = psel && penable;
  assign hit = (paddr == OFS_CAUSE) || (paddr == OFS_CTRL)
            || (paddr == OFS_STAT);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else if (internal_reset) begin
      ctrl_q <= CTRL_RST;
    end else if (acc && pwrite && (paddr == OFS_CTRL)) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && (!hit
              || (pwrite && (paddr != OFS_CTRL)));
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          OFS_CAUSE: prdata <= {24'h000000, cause_q};
          OFS_CTRL:  prdata <= {29'h0, ctrl_q};
          OFS_STAT:  prdata <= {16'h0000, 5'h00, st_q, cnt_q[12:5]};
          default:   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------
  // wait mode; the cpu strobe is a pulse, so remember it until wake
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b0;
    end else if (cpu.wait_exec && (st_q == ST_RUN)) begin
      wait_q <= 1'b1;
    end else if (cpu.wake || (st_q != ST_RUN)) begin
      wait_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // outputs, registered
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_pin_out    <= 1'b0;
      rst_pin_oe_n   <= 1'b0;
      internal_reset <= 1'b1;
      vector_addr    <= VEC_USER;
      gen_clock_out  <= 1'b1;
      cpu_clk_en     <= 1'b0;
      per_clk_en     <= 1'b0;
    end else begin
      rst_pin_out    <= 1'b0;
      rst_pin_oe_n   <= !((st_q == ST_STAB) || (st_q == ST_DRIVE));
      internal_reset <= (st_q != ST_RUN) && (st_q != ST_STOP)
                     && (st_q != ST_WAKE);
      vector_addr    <= ctrl_mon ? VEC_MON : VEC_USER;
      gen_clock_out  <= 1'b1;
      per_clk_en     <= (st_q == ST_RUN) || (st_q == ST_HOLD);
      cpu_clk_en     <= (st_q == ST_RUN) && !cpu.wait_exec && !wait_q;
    end
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  hold_after_drive_a: assert property (
    $rose(rst_pin_oe_n) && (st_q == ST_HOLD) |-> internal_reset [*8])
    else $error("internal reset dropped too soon after pin release");
  opc_flag_a: assert property (
    running && cpu.bad_opcode |=> cause_q[B_OPC])
    else $error("bad opcode flag not set");
  adr_data_a: assert property (
    running && cpu.unmapped && !cpu.opcode_fetch && !wd_ovf && !opc_ev
    && !lvi_ev |=> st_q != ST_DRIVE)
    else $error("data fetch caused reset");
  cnt_clear_a: assert property (
    int_ev |=> cnt_q == '0)
    else $error("internal reset did not clear counter");
  svc_clear_a: assert property (
    svc_wr && !int_ev && st_q != ST_STOP |=> cnt_q[12:4] == 9'h000)
    else $error("service write left upper counter bits");
  tick_once_a: assert property (
    wdog_tick |=> !wdog_tick)
    else $error("watchdog tick longer than one cycle");
  wd_gate_a: assert property (
    ctrl_mon && hv_rst |=> wd_q == 8'h00)
    else $error("watchdog ran under high voltage");
  stop_bad_a: assert property (
    running && cpu.stop_exec && !ctrl_halt |=> st_q == ST_DRIVE)
    else $error("stop without halt enable did not reset");
  wait_gate_a: assert property (
    st_q == ST_RUN && cpu.wait_exec |=> !cpu_clk_en && per_clk_en)
    else $error("wait mode clock gating wrong");
  wait_hold_a: assert property (
    wait_q |=> !cpu_clk_en)
    else $error("cpu clock ran while waiting");
  cause_ro_a: assert property (
    acc && pwrite && paddr == OFS_CAUSE && !int_ev && !pin_qual
    |=> $stable(cause_q))
    else $error("cause register changed by write");

  int_rst_c: cover property (int_ev ##1 st_q == ST_DRIVE);
  stop_wake_c: cover property (st_q == ST_WAKE ##1 st_q == ST_RUN);
  pin_flag_c: cover property (pin_qual);
  tick_c: cover property (wdog_tick);

endmodule
`default_nettype wire

/* bench/rss_far_end.sv */
`timescale 1ns/1ns
`default_nettype none
module rss_far_end (
  input  wire logic rst_pin_out,  // device drive value on the reset pin
  input  wire logic rst_pin_oe_n, // device drives the pin while low
  input  wire logic ext_low,      // outside logic pulls the pin low
  output logic      pin_level     // resolved pin level seen by all
);
  // -------------------------------------------------------------------
  // reset pin wire
  // -------------------------------------------------------------------
  // open-drain wire with a pull-up: a released pin reads high, never
  // the last driven value; the outside holds it low as long as told
  always_comb begin
    pin_level = (rst_pin_oe_n ? 1'b1 : rst_pin_out) & ~ext_low;
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rss_pkg::*;
  // -------------------------------------------------------------------
  // setup
  // -------------------------------------------------------------------
  localparam int unsigned STAB_SIM = 64; // shortened long count
  localparam int unsigned WD_SIM   = 2;  // ticks per watchdog timeout
  logic        ref_clk, rst, lvi_in, wdog_rst_in, hv_rst, hv_irq;
  logic        brk_state, ext_low, pin_level, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, rst_pin_out, rst_pin_oe_n, err;
  logic        internal_reset, gen_clock_out, cpu_clk_en, per_clk_en;
  logic        wdog_tick;
  logic [15:0] vector_addr;
  rss_cpu_t    cpu;
  int          fail_count, checked, n, m, rst_seen;

  rss_seq #(.STAB_N(STAB_SIM), .PINP_N(131), .WDOG_N(WD_SIM)) rss_seq_i (
    .ref_clk, .rst, .lvi_in, .wdog_rst_in, .rst_pin_in(pin_level),
    .hv_rst, .hv_irq, .brk_state, .cpu, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rst_pin_out,
    .rst_pin_oe_n, .internal_reset, .vector_addr, .gen_clock_out,
    .cpu_clk_en, .per_clk_en, .wdog_tick);
  rss_far_end rss_far_end_i (.rst_pin_out, .rst_pin_oe_n, .ext_low,
    .pin_level);

  // free clock; reset events counted to spot unwanted resets
  always #10 ref_clk = ~ref_clk;
  always @(posedge internal_reset) rst_seen++;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hang(input string nm);
    fail_count++;
    $display("ERROR %s expected done seen timeout", nm);
    print_verdict();
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) hang("apb ready");
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cpu_ev(input rss_cpu_t v);
    @(posedge ref_clk);
    cpu <= v;
    @(posedge ref_clk);
    cpu <= '0;
  endtask

  // n: cycles the pin is driven, m: internal-only tail after it
  task automatic seq_len;
    int k;
    k = 0;
    n = 0;
    m = 0;
    while (rst_pin_oe_n !== 1'b0 && k < 300) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 300) hang("pin drive");
    while (rst_pin_oe_n === 1'b0 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    while (internal_reset === 1'b1 && m < 300) begin
      @(negedge ref_clk);
      m++;
    end
  endtask

  task automatic settle;
    int k;
    k = 0;
    while (internal_reset !== 1'b0 && k < 20000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k == 20000) hang("release");
  endtask

  task automatic clk_on;
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 6000) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 6000) hang("clock on");
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_por;
    chk("por cpu clk", cpu_clk_en, 1'b0);
    @(negedge ref_clk);
    seq_len();
    // pin already driven at release; the output flop adds one at the end
    chk("por drive", n, STAB_SIM + DRIVE_CYC + 1);
    chk("por tail", m, HOLD_CYC);
    chk("clock out", gen_clock_out, 1'b1);
    chk("vector", vector_addr, VEC_USER);
    apb(1'b0, OFS_CAUSE, 32'h0);
    chk("por cause", rdat, {24'h0, CAUSE_RST});
    $display("test por done");
  endtask

  // read-only cause, refused offset, monitor vector, defaults on reset
  task automatic t_regs;
    rss_cpu_t v;
    v = '0;
    v.bad_opcode = 1'b1;
    apb(1'b1, OFS_CAUSE, 32'h0);
    chk("ro err", err, 1'b1);
    apb(1'b0, OFS_CAUSE, 32'h0);
    chk("ro kept", rdat, 32'h80);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", err, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h4);
    repeat (3) @(negedge ref_clk);
    chk("mon vector", vector_addr, VEC_MON);
    cpu_ev(v);
    seq_len();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl default", rdat[2:0], CTRL_RST);
    chk("user vector", vector_addr, VEC_USER);
    $display("test regs done");
  endtask

  // each internal source but low voltage: timing, own flag, counter cleared
  task automatic t_src;
    rss_cpu_t ev [3];
    int       bn [4];
    ev[0] = '0;
    ev[0].bad_opcode = 1'b1;
    ev[1] = '0;
    ev[1].stop_exec = 1'b1;
    ev[2] = '0;
    ev[2].opcode_fetch = 1'b1;
    ev[2].unmapped = 1'b1;
    bn = '{B_OPC, B_OPC, B_ADR, B_WDG};
    for (int i = 0; i < 4; i++) begin
      if (i < 3) begin
        cpu_ev(ev[i]);
      end else begin
        @(posedge ref_clk);
        wdog_rst_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wdog_rst_in <= 1'b0;
      end
      seq_len();
      chk("int drive", n, DRIVE_CYC);
      chk("int tail", m, HOLD_CYC);
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk("cause bit", rdat[bn[i]], 1'b1);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("cnt cleared", rdat[7:0] < 8'h04, 1'b1);
    end
    ev[2].opcode_fetch = 1'b0;
    cpu_ev(ev[2]);
    repeat (20) @(negedge ref_clk);
    chk("data fetch", internal_reset, 1'b0);
    $display("test sources done");
  endtask

  task automatic t_wait;
    rss_cpu_t v;
    v = '0;
    v.wait_exec = 1'b1;
    cpu_ev(v);
    repeat (3) @(negedge ref_clk);
    chk("wait cpu", cpu_clk_en, 1'b0);
    chk("wait per", per_clk_en, 1'b1);
    v = '0;
    v.wake = 1'b1;
    cpu_ev(v);
    clk_on();
    $display("test wait done");
  endtask

  // short and long stop recovery; long must outlast the short count
  task automatic t_stop;
    rss_cpu_t st, wk;
    st = '0;
    st.stop_exec = 1'b1;
    wk = '0;
    wk.wake = 1'b1;
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, OFS_CTRL, 32'h2 | s);
      cpu_ev(st);
      repeat (3) @(negedge ref_clk);
      chk("stop clocks", {cpu_clk_en, per_clk_en}, 2'b00);
      cpu_ev(wk);
      clk_on();
      if (s == 1)
        chk("short", n >= SHORT_CYC - 2 && n <= SHORT_CYC + 3, 1'b1);
      else
        chk("long", n > SHORT_CYC + 8, 1'b1);
    end
    $display("test stop done");
  endtask

  // short pulse sets no flag; long one does; counter never cleared
  task automatic t_pin;
    logic [31:0] s0;
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, OFS_STAT, 32'h0);
      s0 = rdat;
      @(posedge ref_clk);
      ext_low <= 1'b1;
      repeat (i ? 80 : 40) @(posedge ref_clk);
      ext_low <= 1'b0;
      settle();
      apb(1'b0, OFS_CAUSE, 32'h0);
      chk("pin flag", rdat[B_PIN], i[0]);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("cnt kept", rdat[7:0] > s0[7:0], 1'b1);
    end
    $display("test pin done");
  endtask

  task automatic t_lowv;
    @(posedge ref_clk);
    lvi_in <= 1'b1;
    seq_len();
    chk("lowv drive", n, STAB_SIM + DRIVE_CYC);
    chk("lowv tail", m, HOLD_CYC);
    apb(1'b0, OFS_CAUSE, 32'h0);
    chk("lowv flag", rdat[B_LVI], 1'b1);
    @(posedge ref_clk);
    lvi_in <= 1'b0;
    $display("test low voltage done");
  endtask

  // serviced, then disabled two ways, then left to time out
  task automatic t_wdog;
    rss_cpu_t sv;
    int       r0;
    int       tk;
    sv = '0;
    sv.wr = 1'b1;
    sv.addr = SVC_ADDR;
    r0 = rst_seen;
    for (int k = 0; k < 18; k++) begin
      cpu_ev(sv);
      repeat (1000) @(posedge ref_clk);
    end
    chk("serviced", rst_seen - r0, 0);
    apb(1'b1, OFS_CTRL, 32'h4);
    for (int j = 0; j < 2; j++) begin
      @(posedge ref_clk);
      hv_irq <= (j == 0);
      hv_rst <= (j == 1);
      brk_state <= (j == 1);
      repeat (17000) @(posedge ref_clk);
      chk("hv disable", rst_seen - r0, 0);
    end
    @(posedge ref_clk);
    hv_rst <= 1'b0;
    brk_state <= 1'b0;
    m = 0;
    tk = 0;
    while (rst_seen == r0 && m < 2 * 8192 + 100) begin
      @(negedge ref_clk);
      m++;
      if (wdog_tick === 1'b1) tk++;
    end
    chk("timeout", rst_seen - r0, 1);
    chk("ticks", tk, WD_SIM);
    settle();
    $display("test watchdog done");
  endtask

  task automatic t_por2;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    apb(1'b0, OFS_CAUSE, 32'h0);
    chk("por clears", rdat, 32'h80);
    $display("test second por done");
  endtask

  // main sequence: inputs defined at time zero, reset for 8 cycles
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {lvi_in, wdog_rst_in, hv_rst, hv_irq, brk_state, ext_low} = '0;
    {psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    cpu = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    t_por();
    t_regs();
    t_src();
    t_wait();
    t_stop();
    t_pin();
    t_lowv();
    t_wdog();
    t_por2();
    print_verdict();
  end
endmodule
`default_nettype wire
